//--- hw/atls_supervisor.v
// Two-axis travel limit supervisor
`timescale 1ns/1ps
`default_nettype none
`include "atls_map.vh"
module atls_supervisor
(
	input  wire                          i_clock,
	input  wire                          i_rst_b,
	input  wire [`ATLS_AXES-1:0]         i_travel_end_plus,
	input  wire [`ATLS_AXES-1:0]         i_travel_end_minus,
	input  wire [`ATLS_AXES-1:0]         i_stop_mode_slow,
	input  wire [`ATLS_AXES-1:0]         i_soft_limit_en,
	input  wire [`ATLS_POS_W-1:0]        i_upper_x,
	input  wire [`ATLS_POS_W-1:0]        i_lower_x,
	input  wire [`ATLS_POS_W-1:0]        i_upper_y,
	input  wire [`ATLS_POS_W-1:0]        i_lower_y,
	input  wire [`ATLS_POS_W-1:0]        i_position_x,
	input  wire [`ATLS_POS_W-1:0]        i_position_y,
	input  wire [`ATLS_AXES-1:0]         i_moving,
	input  wire [`ATLS_AXES-1:0]         i_dir_plus,
	input  wire [`ATLS_AXES-1:0]         i_home_active,
	input  wire [`ATLS_AXES-1:0]         i_home_offset_step,
	output wire [`ATLS_AXES-1:0]         o_stop_instant,
	output wire [`ATLS_AXES-1:0]         o_stop_slow,
	output wire [`ATLS_AXES-1:0]         o_block_plus,
	output wire [`ATLS_AXES-1:0]         o_block_minus,
	output wire [`ATLS_AXES-1:0]         o_soft_out,
	output wire [`ATLS_AXES-1:0]         o_home_end
);

	// Sensor pins are asynchronous: two flops before any use
	reg [`ATLS_AXES-1:0] plus_meta_q;
	reg [`ATLS_AXES-1:0] plus_sync_q;
	reg [`ATLS_AXES-1:0] minus_meta_q;
	reg [`ATLS_AXES-1:0] minus_sync_q;

	always @(posedge i_clock)
	begin
		if (!i_rst_b)
		begin
			plus_meta_q  <= {`ATLS_AXES{1'b0}};
			plus_sync_q  <= {`ATLS_AXES{1'b0}};
			minus_meta_q <= {`ATLS_AXES{1'b0}};
			minus_sync_q <= {`ATLS_AXES{1'b0}};
		end
		else
		begin
			plus_meta_q  <= i_travel_end_plus;
			plus_sync_q  <= plus_meta_q;
			minus_meta_q <= i_travel_end_minus;
			minus_sync_q <= minus_meta_q;
		end
	end

	// Signed window test, used by both axes
	function out_of_range;
		input [`ATLS_POS_W-1:0] pos;
		input [`ATLS_POS_W-1:0] upper;
		input [`ATLS_POS_W-1:0] lower;
		begin
			out_of_range = ($signed(pos) > $signed(upper)) ||
				($signed(pos) < $signed(lower));
		end
	endfunction

	// Per-axis bound selection
	wire [`ATLS_POS_W-1:0] pos_w   [0:`ATLS_AXES-1];
	wire [`ATLS_POS_W-1:0] upper_w [0:`ATLS_AXES-1];
	wire [`ATLS_POS_W-1:0] lower_w [0:`ATLS_AXES-1];
	// (R3) separate bound pairs
	assign pos_w[0]   = i_position_x;
	assign pos_w[1]   = i_position_y;
	assign upper_w[0] = i_upper_x;
	assign upper_w[1] = i_upper_y;
	assign lower_w[0] = i_lower_x;
	assign lower_w[1] = i_lower_y;

	genvar ax;
	generate
		for (ax = 0; ax < `ATLS_AXES; ax = ax + 1)
		begin : g_axis
			// Window and direction terms of this axis
			wire soft_hit;
			wire hw_toward;
			wire above_upper;
			wire below_lower;
			wire soft_toward;

			// Next values of the output flops
			reg  stop_instant_d;
			reg  stop_slow_d;
			reg  block_plus_d;
			reg  block_minus_d;
			reg  soft_out_d;
			reg  home_end_d;

			// Output flops, one per request line
			reg  stop_instant_q;
			reg  stop_slow_q;
			reg  block_plus_q;
			reg  block_minus_q;
			reg  soft_out_q;
			reg  home_end_q;

			// (R5) internal position compare
			// (R2) enable gate; (R7) home mute
			assign soft_hit = i_soft_limit_en[ax] && !i_home_active[ax] &&
				out_of_range(pos_w[ax], upper_w[ax], lower_w[ax]);

			// (R9) limit ahead only
			assign hw_toward = i_dir_plus[ax] ? plus_sync_q[ax] : minus_sync_q[ax];

			// Strictly beyond each bound; a bound itself is still inside
			assign above_upper = $signed(pos_w[ax]) > $signed(upper_w[ax]);
			assign below_lower = $signed(pos_w[ax]) < $signed(lower_w[ax]);

			// Soft stop only when heading further out, so recovery is possible
			assign soft_toward = i_dir_plus[ax] ? above_upper : below_lower;

			// Next-state terms, from this cycle's inputs and the synced sensor flops
			always @*
			begin
				stop_instant_d = 1'b0;
				stop_slow_d    = 1'b0;
				block_plus_d   = 1'b0;
				block_minus_d  = 1'b0;
				soft_out_d     = 1'b0;
				home_end_d     = 1'b0;

				// (R6) hardware stop always
				if (i_moving[ax] && hw_toward)
				begin
					// (R1) mode picks stop
					if (i_stop_mode_slow[ax] == `ATLS_STOP_INST)
						stop_instant_d = 1'b1;
					else
						stop_slow_d = 1'b1;
				end

				// (R4) soft decelerating stop
				if (i_moving[ax] && soft_hit && soft_toward)
					stop_slow_d = 1'b1;

				// (R9) plus side inhibit
				if (plus_sync_q[ax])
					block_plus_d = 1'b1;
				else if (soft_hit && above_upper)
					block_plus_d = 1'b1;

				// (R9) minus side inhibit
				if (minus_sync_q[ax])
					block_minus_d = 1'b1;
				else if (soft_hit && below_lower)
					block_minus_d = 1'b1;

				// Out-of-window report, whatever the direction
				soft_out_d = soft_hit;

				// (R8) offset move end
				// Limit ahead ends it, at the start of the move or during it
				if (i_home_active[ax] && i_home_offset_step[ax] && hw_toward)
					home_end_d = 1'b1;
			end

			// Output registers; a reset clears every request at once
			always @(posedge i_clock)
			begin
				if (!i_rst_b)
				begin
					stop_instant_q <= 1'b0;
					stop_slow_q    <= 1'b0;
					block_plus_q   <= 1'b0;
					block_minus_q  <= 1'b0;
					soft_out_q     <= 1'b0;
					home_end_q     <= 1'b0;
				end
				else
				begin
					stop_instant_q <= stop_instant_d;
					stop_slow_q    <= stop_slow_d;
					block_plus_q   <= block_plus_d;
					block_minus_q  <= block_minus_d;
					soft_out_q     <= soft_out_d;
					home_end_q     <= home_end_d;
				end
			end

			// Outputs straight from the flops, no glitches toward the drive
			assign o_stop_instant[ax] = stop_instant_q;
			assign o_stop_slow[ax]    = stop_slow_q;
			assign o_block_plus[ax]   = block_plus_q;
			assign o_block_minus[ax]  = block_minus_q;
			assign o_soft_out[ax]     = soft_out_q;
			assign o_home_end[ax]     = home_end_q;
		end
	endgenerate

endmodule
`default_nettype wire

//--- inc/atls_map.vh
// Constants for the two-axis travel limit supervisor
// Overview of operation
// (R1) Plus/minus travel end inputs stop drive, instant or decelerating per stop mode.
// (R2) Software bounds are checked only while the software limit enable is on.
// (R3) Each axis holds its own upper and lower software bound.
// (R4) Position outside lower..upper bounds gives a decelerating stop. The code stops only an axis that is moving further out of the window.
// (R5) Software limit is computed from the internal position counter only.
// (R6) Hardware limit stopping acts regardless of software limit settings.
// (R7) During home search only hardware limits stop the drive.
// (R8) Offset move of home search ends on limit in motion direction.
// (R9) A limit blocks only motion toward it; moving away stays allowed.
`ifndef ATLS_MAP_VH
`define ATLS_MAP_VH
`define ATLS_POS_W      32
`define ATLS_AXES       2
`define ATLS_STOP_SLOW  1'b1
`define ATLS_STOP_INST  1'b0
`define ATLS_UPPER_RST  32'h000186a0
`define ATLS_LOWER_RST  32'hffff3cb0
`endif

//--- bench/atls_sensor_model.sv
// Travel end switch model for both axes
`timescale 1ns/1ps
`default_nettype none
module atls_sensor_model #(parameter int HX = 100002, LX = -50002, HY = 1002, LY = -1002)
	(input wire logic signed [31:0] i_position_x, i_position_y, output logic [1:0] o_plus, o_minus);
	// Switches sit just past the soft bounds, so both limits get hit
	assign o_plus = {i_position_y >= HY, i_position_x >= HX};
	assign o_minus = {i_position_y <= LY, i_position_x <= LX};
endmodule
`default_nettype wire

//--- bench/atls_props.sv
// Port assertions for the travel limit supervisor
`timescale 1ns/1ps
`default_nettype none
module atls_props
(
	input wire logic i_clock, i_rst_b,
	input wire logic [1:0] i_travel_end_plus, i_travel_end_minus, i_stop_mode_slow, i_moving,
	input wire logic [1:0] i_soft_limit_en, i_dir_plus, i_home_active, i_home_offset_step,
	input wire logic [1:0] o_stop_instant, o_block_minus, o_soft_out, o_home_end
);
	logic [1:0] n_q;
	// Sensor history only counts two edges after reset
	always @(posedge i_clock) n_q <= i_rst_b ? n_q | {n_q[0], 1'b1} : 2'h0;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	AST_OFF: assert property (!i_soft_limit_en[0] |=> !o_soft_out[0]) else $error("soft");
	AST_HOME: assert property (i_home_active[1] |=> !o_soft_out[1]) else $error("home");
	AST_IDLE: assert property (!i_moving[0] |=> !o_stop_instant[0]) else $error("idle");
	AST_END: assert property (!i_home_active[0] |=> !o_home_end[0]) else $error("end");
	AST_MODE: assert property (o_stop_instant[1] |-> !$past(i_stop_mode_slow[1])) else $error("mode");
	AST_BLK: assert property (n_q[1] && $past(i_travel_end_minus[1], 2) |=> o_block_minus[1])
		else $error("block");
	AST_STOP: assert property (n_q[1] && $past(i_travel_end_plus[0], 2) && i_moving[0] &&
		i_dir_plus[0] && !i_stop_mode_slow[0] |=> o_stop_instant[0]) else $error("stop");
	AST_OFFSET: assert property (n_q[1] && i_home_active[0] && i_home_offset_step[0] &&
		!i_dir_plus[0] && $past(i_travel_end_minus[0], 2) |=> o_home_end[0]) else $error("offset");
endmodule
bind atls_supervisor atls_props u_atls_props (.*);
`default_nettype wire

//--- bench/atls_supervisor_tb_top.sv
// Random bench for the travel limit supervisor
`timescale 1ns/1ps
`default_nettype none
`include "atls_map.vh"
module atls_supervisor_tb_top;
	logic i_clock = 1'b0, i_rst_b = 1'b0;
	logic [1:0] i_travel_end_plus, i_travel_end_minus, i_stop_mode_slow, i_soft_limit_en, i_moving;
	logic [1:0] i_dir_plus, i_home_active, i_home_offset_step;
	logic [31:0] i_upper_x = `ATLS_UPPER_RST, i_lower_x = `ATLS_LOWER_RST, i_position_x;
	logic [31:0] i_upper_y = 32'h3e8, i_lower_y = 32'hfffffc18, i_position_y, r = 32'h2e;
	wire [1:0] o_stop_instant, o_stop_slow, o_block_plus, o_block_minus, o_soft_out, o_home_end;
	int mismatches = 0, num_checks = 0;
	always #10 i_clock = ~i_clock;
	atls_sensor_model u_sens (.o_plus(i_travel_end_plus), .o_minus(i_travel_end_minus), .*);
	atls_supervisor u_atls_supervisor (.*);
	// Expected flag: armed, not homing, strictly outside
	function automatic logic oob(int a);
		logic signed [31:0] p = a ? i_position_y : i_position_x, u = a ? i_upper_y : i_upper_x;
		logic signed [31:0] l = a ? i_lower_y : i_lower_x;
		return i_soft_limit_en[a] && !i_home_active[a] && (p > u || p < l);
	endfunction
	// Xorshift draw; positions land on and around each bound
	task automatic pick();
		r ^= r << 13;
		r ^= r >> 17;
		r ^= r << 5;
		{i_stop_mode_slow, i_soft_limit_en, i_moving, i_dir_plus, i_home_active} = r[31:22];
		i_home_offset_step = r[21:20];
		i_position_x = (r[0] ? i_upper_x : i_lower_x) + r[4:2] - 32'h4;
		i_position_y = (r[1] ? i_upper_y : i_lower_y) + r[7:5] - 32'h4;
	endtask
	// Expected request w of axis a from current inputs and sensors
	function automatic logic exp_out(int a, int w);
		logic signed [31:0] p, u, l;
		logic arm, tow;
		p = a ? i_position_y : i_position_x;
		u = a ? i_upper_y : i_upper_x;
		l = a ? i_lower_y : i_lower_x;
		arm = i_soft_limit_en[a] && !i_home_active[a];
		tow = i_dir_plus[a] ? i_travel_end_plus[a] : i_travel_end_minus[a];
		case (w)
			0: return i_moving[a] && tow && !i_stop_mode_slow[a];
			1: return i_moving[a] && ((tow && i_stop_mode_slow[a]) ||
				(arm && (i_dir_plus[a] ? p > u : p < l)));
			2: return i_travel_end_plus[a] || (arm && p > u);
			3: return i_travel_end_minus[a] || (arm && p < l);
			default: return i_home_active[a] && i_home_offset_step[a] && tow;
		endcase
	endfunction
	task automatic chk(string n, logic [1:0] s, x);
		num_checks++;
		mismatches += int'(s !== x);
		if (s !== x)
			$display("wrong value %s exp %h got %h", n, x, s);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Inputs held four cycles so synced sensors settle
	initial
	begin
		for (int k = 0; k < 1200; k++)
		begin
			if (k % 4 == 0)
				pick();
			@(posedge i_clock);
			#1 i_rst_b = !(k < 6 || k == 600 || k == 601);
			if (k > 6 && (k < 601 || k > 607))
			begin
				chk("soft_out", o_soft_out, {oob(1), oob(0)});
				if (k % 4 >= 2)
				begin
					chk("stop_instant", o_stop_instant, {exp_out(1, 0), exp_out(0, 0)});
					chk("stop_slow", o_stop_slow, {exp_out(1, 1), exp_out(0, 1)});
					chk("block_plus", o_block_plus, {exp_out(1, 2), exp_out(0, 2)});
					chk("block_minus", o_block_minus, {exp_out(1, 3), exp_out(0, 3)});
					chk("home_end", o_home_end, {exp_out(1, 4), exp_out(0, 4)});
				end
			end
			if (k == 602)
				chk("reset", o_stop_instant | o_stop_slow | o_block_plus | o_block_minus |
					o_soft_out | o_home_end, 2'h0);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
